// *** scg_gate.sv ***
`timescale 1ns/10ps
// How it works
// - after any reset, fetch address goes to program address zero
// - interrupts vector to 4-byte slots, power-on slot one up to sleep timer
// - data ram holds at most 256 bytes
// - flash control register answers only while the supervisory rom runs
// - four auxiliary rows survive a full erase untouched
// - two port pins enter serial mode; test queue then issues calls
// - call opcode zero moves control into supervisory rom space
// - undefined function code from user code halts the processor
// - first guard key must read 3Ah at call time
// - second guard key must equal stack pointer plus three
// - either key wrong halts the processor, boot reset excepted
// - parameter block sits at F8h to FFh in fixed order
// - return code is written to the first guard key location
// - checksum and table fetch put result data there instead
// - return codes: 00h ok, 01h protected, 02h soft reset, 03h fatal
// - hardware reset clears the accumulator and runs boot reset first
module scg_gate (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic isp_clk_pin,
  input wire logic isp_data_pin,
  output logic [15:0] fetch_addr,
  output logic cpu_halted,
  output logic in_supervisory,
  output logic serial_prog_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  scg_pkg::scg_state_e state, next_state;
  scg_pkg::scg_call_s call, next_call, req;
  logic [7:0] first_guard_key, next_first_guard_key;
  logic [7:0] second_guard_key, next_second_guard_key;
  logic [7:0] rc, next_rc;
  logic [7:0] last_rc, next_last_rc;
  logic [3:0] cnt, next_cnt;
  logic [15:0] next_fetch_addr;
  logic next_cpu_halted;
  logic next_in_supervisory;
  logic [15:0] op_count, next_op_count;
  logic busy;
  logic keys_ok;
  logic fn_defined;
  logic fn_guarded;
  logic blk_protected;
  logic [7:0] aux_sum;
  logic eng_we;
  logic [7:0] eng_addr;
  logic [7:0] eng_wdata;
  logic ram_we;
  logic [7:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic ph, next_ph;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic [31:0] flash_ctrl, next_flash_ctrl;
  logic [31:0] aux [scg_pkg::AUX_ROWS];
  logic [31:0] next_aux [scg_pkg::AUX_ROWS];
  logic access;
  logic wr_fire;
  logic ram_sel;
  logic reg_mapped;
  logic aux_sel;
  logic [31:0] reg_rdata;
  logic call_start;
  logic vec_write;
  logic [4:0] vec_slot;

  ////////////////////////////////////////////////////////////////////////////
  // data ram, shared by the call engine and the apb window

  // engine owns the port while busy; apb ram accesses wait for it
  assign ram_we = busy ? eng_we : (wr_fire & ram_sel);
  assign ram_addr = busy ? eng_addr : paddr[9:2];
  assign ram_wdata = busy ? eng_wdata : pwdata[7:0];

  scg_ram u_ram (
    .pclk(pclk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // call engine

  // busy covers every state where supervisory code runs
  assign busy = (state != scg_pkg::ST_IDLE) && (state != scg_pkg::ST_HALT);
  assign keys_ok = (first_guard_key == scg_pkg::FIRST_GUARD_KEY_VALUE) &&
                   (second_guard_key == 8'(call.sp + scg_pkg::SECOND_GUARD_KEY_SP_OFFSET));
  assign fn_defined = (call.func <= scg_pkg::FN_CHECKSUM) && (call.func != scg_pkg::FN_UNDEFINED);
  assign fn_guarded = (call.func == scg_pkg::FN_BLOCK_READ) || (call.func == scg_pkg::FN_BLOCK_WRITE) ||
                      (call.func == scg_pkg::FN_BLOCK_ERASE);
  // protection flags live in auxiliary row zero, one bit per block
  assign blk_protected = aux[0][ram_rdata[4:0]];
  assign aux_sum = aux[0][7:0] ^ aux[1][7:0] ^ aux[2][7:0] ^ aux[3][7:0];

  // next-state logic for the supervisory call sequence
  always_comb
  begin
    next_state = state;
    next_call = call;
    next_first_guard_key = first_guard_key;
    next_second_guard_key = second_guard_key;
    next_rc = rc;
    next_last_rc = last_rc;
    next_cnt = cnt;
    next_fetch_addr = fetch_addr;
    next_cpu_halted = cpu_halted;
    next_in_supervisory = in_supervisory;
    next_op_count = op_count;
    eng_we = 1'b0;
    eng_addr = scg_pkg::PB_FIRST_GUARD_KEY;
    eng_wdata = rc;
    unique case (state)
      scg_pkg::ST_BOOT:
      begin
        next_fetch_addr = scg_pkg::RESET_FETCH_ADDR;
        next_in_supervisory = 1'b0;
        next_state = scg_pkg::ST_IDLE;
      end
      scg_pkg::ST_IDLE:
      begin
        if (call_start)
        begin
          next_call = req;
          next_in_supervisory = 1'b1;
          if (req.func == scg_pkg::FN_BOOT_RESET)
          begin
            // boot reset ignores keys and parameter block
            next_last_rc = scg_pkg::RC_SOFT_RESET;
            next_state = scg_pkg::ST_BOOT;
          end
          else
          begin
            next_state = scg_pkg::ST_RD_FIRST_GUARD_KEY;
          end
        end
        else if (vec_write)
        begin
          next_fetch_addr = {9'h000, vec_slot, 2'b00};
        end
      end
      scg_pkg::ST_RD_FIRST_GUARD_KEY:
      begin
        eng_addr = scg_pkg::PB_FIRST_GUARD_KEY;
        next_state = scg_pkg::ST_RD_SECOND_GUARD_KEY;
      end
      scg_pkg::ST_RD_SECOND_GUARD_KEY:
      begin
        eng_addr = scg_pkg::PB_SECOND_GUARD_KEY;
        next_first_guard_key = ram_rdata;
        next_state = scg_pkg::ST_RD_BLOCK;
      end
      scg_pkg::ST_RD_BLOCK:
      begin
        eng_addr = scg_pkg::PB_BLOCK_NUMBER;
        next_second_guard_key = ram_rdata;
        next_state = scg_pkg::ST_CHECK;
      end
      scg_pkg::ST_CHECK:
      begin
        // ram_rdata now holds the block number
        if ((!fn_defined && call.from_user) || !keys_ok)
        begin
          next_cpu_halted = 1'b1;
          next_in_supervisory = 1'b0;
          next_last_rc = scg_pkg::RC_FATAL;
          next_state = scg_pkg::ST_HALT;
        end
        else if (!fn_defined)
        begin
          next_rc = scg_pkg::RC_FATAL;
          next_state = scg_pkg::ST_RETURN;
        end
        else if (fn_guarded && blk_protected)
        begin
          next_rc = scg_pkg::RC_PROTECTED;
          next_state = scg_pkg::ST_RETURN;
        end
        else if (call.func == scg_pkg::FN_TABLE_FETCH)
        begin
          next_rc = aux[ram_rdata[1:0]][7:0];
          next_state = scg_pkg::ST_RETURN;
        end
        else if (call.func == scg_pkg::FN_CHECKSUM)
        begin
          next_rc = aux_sum;
          next_state = scg_pkg::ST_RETURN;
        end
        else
        begin
          next_rc = scg_pkg::RC_SUCCESS;
          next_cnt = 4'(scg_pkg::EXEC_CYCLES - 4'h1);
          next_state = scg_pkg::ST_EXEC;
        end
      end
      scg_pkg::ST_EXEC:
      begin
        // full erase touches user flash only; auxiliary rows are not reachable here
        if (cnt == 4'h0)
        begin
          next_op_count = 16'(op_count + 16'h0001);
          next_state = scg_pkg::ST_RETURN;
        end
        else
        begin
          next_cnt = 4'(cnt - 4'h1);
        end
      end
      scg_pkg::ST_RETURN:
      begin
        eng_we = 1'b1;
        eng_addr = scg_pkg::PB_FIRST_GUARD_KEY;
        eng_wdata = rc;
        next_last_rc = rc;
        next_in_supervisory = 1'b0;
        next_state = scg_pkg::ST_IDLE;
      end
      scg_pkg::ST_HALT:
      begin
        // only reset leaves this state
        next_state = scg_pkg::ST_HALT;
      end
      default:
      begin
        next_state = scg_pkg::ST_HALT;
      end
    endcase
  end

  // hardware reset starts in boot with a cleared accumulator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= scg_pkg::ST_BOOT;
      call <= '0;
      first_guard_key <= scg_pkg::CALL_RETURN_RESET;
      second_guard_key <= scg_pkg::CALL_RETURN_RESET;
      rc <= scg_pkg::CALL_RETURN_RESET;
      last_rc <= scg_pkg::CALL_RETURN_RESET;
      cnt <= 4'h0;
      fetch_addr <= scg_pkg::RESET_FETCH_ADDR;
      cpu_halted <= 1'b0;
      in_supervisory <= 1'b1;
      op_count <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      call <= next_call;
      first_guard_key <= next_first_guard_key;
      second_guard_key <= next_second_guard_key;
      rc <= next_rc;
      last_rc <= next_last_rc;
      cnt <= next_cnt;
      fetch_addr <= next_fetch_addr;
      cpu_halted <= next_cpu_halted;
      in_supervisory <= next_in_supervisory;
      op_count <= next_op_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave and software-visible registers

  assign access = psel & penable;
  assign wr_fire = access & pready & pwrite;
  assign ram_sel = (paddr[11:10] == scg_pkg::RAM_WINDOW_SEL);
  assign aux_sel = (paddr[11:4] == scg_pkg::OFS_AUX_BASE[11:4]);
  assign reg_mapped = ram_sel || aux_sel || (paddr == scg_pkg::OFS_CALL) || (paddr == scg_pkg::OFS_STATUS) ||
                      (paddr == scg_pkg::OFS_VECTOR) || (paddr == scg_pkg::OFS_FLASH_CTRL) ||
                      (paddr == scg_pkg::OFS_TEST_QUEUE) || (paddr == scg_pkg::OFS_OP_COUNT);
  assign req = '{func: pwdata[7:0], sp: pwdata[15:8], from_user: (paddr == scg_pkg::OFS_CALL)};
  // a call is only taken when idle; the test queue needs serial mode
  assign call_start = wr_fire && !cpu_halted && (state == scg_pkg::ST_IDLE) &&
                      ((paddr == scg_pkg::OFS_CALL) ||
                       ((paddr == scg_pkg::OFS_TEST_QUEUE) && serial_prog_mode));
  assign vec_slot = pwdata[4:0];
  assign vec_write = wr_fire && (paddr == scg_pkg::OFS_VECTOR) && !cpu_halted &&
                     (vec_slot >= scg_pkg::VECTOR_FIRST_SLOT) && (vec_slot <= scg_pkg::VECTOR_LAST_SLOT);

  // read mux; flash control hides from user-level software
  always_comb
  begin
    reg_rdata = 32'h0000_0000;
    if (ram_sel)
    begin
      reg_rdata = {24'h00_0000, ram_rdata};
    end
    else if (aux_sel)
    begin
      reg_rdata = aux[paddr[3:2]];
    end
    else if (paddr == scg_pkg::OFS_STATUS)
    begin
      reg_rdata = {fetch_addr, last_rc, 4'h0, serial_prog_mode, in_supervisory, cpu_halted, busy};
    end
    else if (paddr == scg_pkg::OFS_FLASH_CTRL)
    begin
      reg_rdata = in_supervisory ? flash_ctrl : 32'h0000_0000;
    end
    else if (paddr == scg_pkg::OFS_OP_COUNT)
    begin
      reg_rdata = {16'h0000, op_count};
    end
  end

  // two-step access phase: issue, then capture and answer with pready
  always_comb
  begin
    next_ph = ph;
    next_pready = 1'b0;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    next_flash_ctrl = flash_ctrl;
    for (int i = 0; i < scg_pkg::AUX_ROWS; i++)
    begin
      next_aux[i] = aux[i];
    end
    if (access && !pready)
    begin
      if (!ph)
      begin
        // ram window waits while the engine holds the port
        next_ph = !(ram_sel && busy);
      end
      else
      begin
        next_ph = 1'b0;
        next_pready = 1'b1;
        next_prdata = reg_rdata;
        next_pslverr = !reg_mapped;
      end
    end
    if (wr_fire && (paddr == scg_pkg::OFS_FLASH_CTRL) && in_supervisory)
    begin
      next_flash_ctrl = pwdata;
    end
    // auxiliary rows are written only by the external programmer
    if (wr_fire && aux_sel && serial_prog_mode)
    begin
      next_aux[paddr[3:2]] = pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph <= 1'b0;
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      flash_ctrl <= scg_pkg::FLASH_CTRL_RESET;
      serial_prog_mode <= 1'b0;
      for (int i = 0; i < scg_pkg::AUX_ROWS; i++)
      begin
        aux[i] <= scg_pkg::AUX_ROW_RESET;
      end
    end
    else
    begin
      ph <= next_ph;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      flash_ctrl <= next_flash_ctrl;
      serial_prog_mode <= isp_clk_pin & isp_data_pin;
      for (int i = 0; i < scg_pkg::AUX_ROWS; i++)
      begin
        aux[i] <= next_aux[i];
      end
    end
  end

endmodule

// *** scg_gate_assertions.sv ***
`timescale 1ns/10ps
////////////////////////////////////////
module scg_gate_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic isp_clk_pin,
  input wire logic isp_data_pin,
  input wire logic [15:0] fetch_addr,
  input wire logic cpu_halted,
  input wire logic in_supervisory,
  input wire logic serial_prog_mode
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // reset and boot
  chk_reset_fetch: assert property ($rose(presetn) |-> fetch_addr == 16'h0000 && !cpu_halted)
    else $error("fetch address not zero after reset");
  chk_boot_exit: assert property ($rose(presetn) |-> in_supervisory ##[1:3] !in_supervisory)
    else $error("boot did not leave supervisory rom");
  // vector slots are word aligned and end at the sleep timer slot
  chk_fetch_slot: assert property (fetch_addr[1:0] == 2'b00 && fetch_addr <= 16'h0064)
    else $error("fetch address outside vector table");
  ////////////////////////////////////////
  // halt only comes out of a call and holds until reset
  chk_halt_sticky: assert property (cpu_halted |=> cpu_halted)
    else $error("halt released without reset");
  chk_halt_freeze: assert property (cpu_halted |=> $stable(fetch_addr))
    else $error("fetch address moved while halted");
  chk_halt_cause: assert property ($rose(cpu_halted) |-> $past(in_supervisory))
    else $error("halt outside a supervisory call");
  ////////////////////////////////////////
  // bus answers; flash control reads zero from user code
  chk_flash_hidden: assert property (pready && !pwrite && paddr == 12'h00C && !in_supervisory
    && !$past(in_supervisory) |-> prdata == 32'h0)
    else $error("flash control visible to user code");
  chk_ram_limit: assert property (pready && paddr >= 12'h800 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("access past 256 ram bytes accepted");
  chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside a single access cycle");
  // pin pair is synchronised, so allow a few cycles
  chk_serial_on: assert property ((isp_clk_pin && isp_data_pin) [*3] |-> serial_prog_mode)
    else $error("serial mode not entered");
  chk_serial_off: assert property ((!isp_clk_pin) [*3] |-> !serial_prog_mode)
    else $error("serial mode without pin pair");
endmodule

bind scg_gate scg_gate_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .isp_clk_pin, .isp_data_pin, .fetch_addr, .cpu_halted,
  .in_supervisory, .serial_prog_mode);

// *** scg_isp_prog.sv ***
`timescale 1ns/10ps
////////////////////////////////////////
// external programmer on the serial pin pair; pins rest low when it lets go
module scg_isp_prog (
  input wire logic enter,
  output logic isp_clk_pin,
  output logic isp_data_pin
);
  // both pins high asks for serial programming mode
  assign isp_clk_pin = enter;
  assign isp_data_pin = enter;
endmodule

// *** scg_pkg.sv ***
package scg_pkg;

  // supervisory function codes carried in the accumulator
  localparam logic [7:0] FN_BOOT_RESET = 8'h00;
  localparam logic [7:0] FN_BLOCK_READ = 8'h01;
  localparam logic [7:0] FN_BLOCK_WRITE = 8'h02;
  localparam logic [7:0] FN_BLOCK_ERASE = 8'h03;
  localparam logic [7:0] FN_UNDEFINED = 8'h04;
  localparam logic [7:0] FN_FULL_ERASE = 8'h05;
  localparam logic [7:0] FN_TABLE_FETCH = 8'h06;
  localparam logic [7:0] FN_CHECKSUM = 8'h07;

  // guard keys
  localparam logic [7:0] FIRST_GUARD_KEY_VALUE = 8'h3A;
  localparam logic [7:0] SECOND_GUARD_KEY_SP_OFFSET = 8'h03;

  // parameter block in page-zero sram
  localparam logic [7:0] PB_FIRST_GUARD_KEY = 8'hF8;
  localparam logic [7:0] PB_SECOND_GUARD_KEY = 8'hF9;
  localparam logic [7:0] PB_BLOCK_NUMBER = 8'hFA;
  localparam logic [7:0] PB_POINTER = 8'hFB;
  localparam logic [7:0] PB_CLOCK_DIVIDER = 8'hFC;
  localparam logic [7:0] PB_MODE = 8'hFD;
  localparam logic [7:0] PB_DELAY = 8'hFE;
  localparam logic [7:0] PB_PROGRAM_COUNTER_LOW = 8'hFF;

  // return codes
  localparam logic [7:0] RC_SUCCESS = 8'h00;
  localparam logic [7:0] RC_PROTECTED = 8'h01;
  localparam logic [7:0] RC_SOFT_RESET = 8'h02;
  localparam logic [7:0] RC_FATAL = 8'h03;

  // program memory map
  localparam logic [15:0] RESET_FETCH_ADDR = 16'h0000;
  localparam logic [4:0] VECTOR_FIRST_SLOT = 5'h01;
  localparam logic [4:0] VECTOR_LAST_SLOT = 5'h19;
  localparam logic [15:0] USER_CODE_START = 16'h0068;
  localparam logic [15:0] FLASH_LAST_ADDR = 16'h1FFF;

  // data ram and auxiliary rows
  localparam int RAM_DEPTH = 256;
  localparam int AUX_ROWS = 4;
  localparam logic [7:0] CALL_RETURN_RESET = 8'h00;

  // time a flash function holds the engine, in cycles
  localparam logic [3:0] EXEC_CYCLES = 4'h8;

  // apb byte offsets
  localparam logic [11:0] OFS_CALL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_VECTOR = 12'h008;
  localparam logic [11:0] OFS_FLASH_CTRL = 12'h00C;
  localparam logic [11:0] OFS_AUX_BASE = 12'h010;
  localparam logic [11:0] OFS_TEST_QUEUE = 12'h020;
  localparam logic [11:0] OFS_OP_COUNT = 12'h024;
  localparam logic [1:0] RAM_WINDOW_SEL = 2'b01;
  localparam logic [31:0] FLASH_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] AUX_ROW_RESET = 32'h0000_0000;

  typedef enum logic [8:0] {
    ST_BOOT = 9'b0_0000_0001,
    ST_IDLE = 9'b0_0000_0010,
    ST_RD_FIRST_GUARD_KEY = 9'b0_0000_0100,
    ST_RD_SECOND_GUARD_KEY = 9'b0_0000_1000,
    ST_RD_BLOCK = 9'b0_0001_0000,
    ST_CHECK = 9'b0_0010_0000,
    ST_EXEC = 9'b0_0100_0000,
    ST_RETURN = 9'b0_1000_0000,
    ST_HALT = 9'b1_0000_0000
  } scg_state_e;

  typedef struct packed {
    logic [7:0] func;
    logic [7:0] sp;
    logic from_user;
  } scg_call_s;

endpackage

// *** scg_ram.sv ***
`timescale 1ns/10ps
// single-port data ram; read data come out of a register one cycle later
module scg_ram (
  input wire logic pclk,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [scg_pkg::RAM_DEPTH];

  // no reset on the array: contents are undefined until software writes them
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// *** tb_supervisory_call_gate.sv ***
`timescale 1ns/10ps
module tb_supervisory_call_gate;
  typedef struct packed {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] x;
    logic e;
  } scg_row_s;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] FA = 32'hFFFF_0000;
  // caller keeps the stack low enough that the deepest function (11 bytes) still fits
  localparam logic [7:0] SP = 8'h20;
  localparam logic [7:0] K1 = scg_pkg::FIRST_GUARD_KEY_VALUE;
  localparam logic [7:0] K2 = SP + scg_pkg::SECOND_GUARD_KEY_SP_OFFSET;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic isp_clk_pin;
  logic isp_data_pin;
  logic [15:0] fetch_addr;
  logic cpu_halted;
  logic in_supervisory;
  logic serial_prog_mode;
  logic enter = 1'b0;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int tests_run = 0;
  logic [7:0] fn [4] = '{8'h01, 8'h02, 8'h03, 8'h05};
  logic [7:0] aux [4] = '{8'h04, 8'hA5, 8'h3C, 8'h81};
  logic [7:0] bf [4] = '{8'h01, 8'h01, 8'h04, 8'h08};
  logic [7:0] bk1 [4] = '{8'h3B, K1, K1, K1};
  logic [7:0] bk2 [4] = '{K2, K2 - 8'h01, K2, K2};
  scg_row_s rows [17];

  scg_gate u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .isp_clk_pin, .isp_data_pin, .fetch_addr, .cpu_halted, .in_supervisory,
    .serial_prog_mode);
  scg_isp_prog u_prog (.enter, .isp_clk_pin, .isp_data_pin);

  ////////////////////////////////////////
  // clock, 50 ns period
  initial
  begin
    forever #25 pclk = ~pclk;
  end

  // watchdog: the whole run needs under a thousand cycles, so 20,000 cycles is ample
  initial
  begin
    #1_000_000;
    miscompares++;
    stop_test();
  end

  ////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // apb master: request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (pready !== 1'b1 && n < 60);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 60)
        cmp(32'h1, 32'h0);
    end
  endtask

  // caller side: keys and block number first, then the call; poll until idle or halted
  task automatic call(input logic [11:0] p, input logic [7:0] f, input logic [7:0] k1,
    input logic [7:0] k2, input logic [7:0] b);
    int n;
    begin
      n = 0;
      apb(1'b1, 12'h7E0, {24'h0, k1});
      apb(1'b1, 12'h7E4, {24'h0, k2});
      apb(1'b1, 12'h7E8, {24'h0, b});
      apb(1'b1, p, {16'h0, SP, f});
      do
      begin
        apb(1'b0, 12'h004, 32'h0);
        n++;
      end
      while (rd[1:0] === 2'b01 && n < 40);
    end
  endtask

  // a call followed by a look at the first parameter byte
  task automatic fchk(input logic [11:0] p, input logic [7:0] f, input logic [7:0] k1,
    input logic [7:0] k2, input logic [7:0] b, input logic [31:0] x);
    call(p, f, k1, k2, b);
    apb(1'b1 ^ 1'b1, 12'h7E0, 32'h0);
    cmp(rd, x);
  endtask

  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic stop_test();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    rows = '{
      '{1'b0, 12'h004, 32'h0, FA, 32'h0, 1'b0},
      '{1'b0, 12'h00C, 32'h0, ALL, 32'h0, 1'b0},
      '{1'b1, 12'h00C, ALL, ALL, 32'h0, 1'b0},
      '{1'b0, 12'h00C, 32'h0, ALL, 32'h0, 1'b0},
      '{1'b1, 12'h008, 32'h1, ALL, 32'h0, 1'b0},
      '{1'b0, 12'h004, 32'h0, FA, 32'h0004_0000, 1'b0},
      '{1'b1, 12'h008, 32'h19, ALL, 32'h0, 1'b0},
      '{1'b0, 12'h004, 32'h0, FA, 32'h0064_0000, 1'b0},
      '{1'b1, 12'h008, 32'h1A, ALL, 32'h0, 1'b0},
      '{1'b0, 12'h004, 32'h0, FA, 32'h0064_0000, 1'b0},
      '{1'b1, 12'h7E0, 32'h013A, ALL, 32'h0, 1'b0},
      '{1'b0, 12'h7E0, 32'h0, ALL, 32'h003A, 1'b0},
      '{1'b0, 12'h800, 32'h0, ALL, 32'h0, 1'b1},
      '{1'b1, 12'h010, 32'h00FF, ALL, 32'h0, 1'b0},
      '{1'b0, 12'h010, 32'h0, ALL, 32'h0, 1'b0},
      '{1'b0, 12'h024, 32'h0, ALL, 32'h0, 1'b0},
      '{1'b0, 12'h004, 32'h0, 32'h000F, 32'h0, 1'b0}};
    rst();
    // plain register traffic from the table
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      cmp({31'h0, er}, {31'h0, rows[i].e});
      if (!rows[i].w)
        cmp(rd & rows[i].m, rows[i].x);
    end
    // good flash functions return success and count
    for (int i = 0; i < 4; i++)
    begin
      fchk(12'h000, fn[i], K1, K2, 8'h00, 32'h0);
      apb(1'b0, 12'h024, 32'h0);
      cmp(rd, 32'(i + 1));
    end
    // boot with bad keys does not halt and leaves the block alone
    fchk(12'h000, 8'h00, 8'h55, 8'h00, 8'h00, 32'h55);
    apb(1'b0, 12'h004, 32'h0);
    cmp(rd & 32'hFFFF_FF02, 32'h0000_0200);
    // serial mode: protection, result data, queue calls
    enter <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    cmp(rd & 32'h8, 32'h8);
    for (int i = 0; i < 4; i++)
      apb(1'b1, 12'(16 + 4 * i), {24'h0, aux[i]});
    fchk(12'h000, 8'h02, K1, K2, 8'h02, 32'h01);
    fchk(12'h020, 8'h06, K1, K2, 8'h01, 32'hA5);
    fchk(12'h000, 8'h07, K1, K2, 8'h00, {24'h0, aux[0] ^ aux[1] ^ aux[2] ^ aux[3]});
    fchk(12'h020, 8'h04, K1, K2, 8'h00, 32'h03);
    fchk(12'h000, 8'h05, K1, K2, 8'h03, 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    cmp(rd, 32'h5);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'(16 + 4 * i), 32'h0);
      cmp(rd, {24'h0, aux[i]});
    end
    enter <= 1'b0;
    // bad keys and undefined codes halt; later calls are ignored
    for (int i = 0; i < 4; i++)
    begin
      rst();
      call(12'h000, bf[i], bk1[i], bk2[i], 8'h00);
      cmp({31'h0, cpu_halted}, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      cmp(rd & 32'hFF02, 32'h0302);
      fchk(12'h000, 8'h01, K1, K2, 8'h00, {24'h0, K1});
      apb(1'b0, 12'h024, 32'h0);
      cmp(rd, 32'h0);
    end
    rst();
    cmp({31'h0, cpu_halted}, 32'h0);
    cmp({16'h0, fetch_addr}, 32'h0);
    stop_test();
  end
endmodule
